/* bench/tbgpio_board.sv */
// board model: resolves each pin from device drive, external drive or a floating pattern
`timescale 1ns/1ns
module tbgpio_board
(
    input wire logic ref_clk,
    input wire tbgpio_pkg::tbgpio_drive_t dev_a,
    input wire tbgpio_pkg::tbgpio_drive_t dev_b,
    input wire tbgpio_pkg::tbgpio_drive_t dev_c,
    input wire tbgpio_pkg::tbgpio_drive_t ext_a,
    input wire tbgpio_pkg::tbgpio_drive_t ext_b,
    input wire tbgpio_pkg::tbgpio_drive_t ext_c,
    output logic [7:0] pin_a,
    output logic [7:0] pin_b,
    output logic [7:0] pin_c
);
    import tbgpio_pkg::*;
    // no pulls: an undriven pin toggles each cycle so a stale level never passes
    logic [7:0] flt = 8'h5A;
    always @(posedge ref_clk) flt <= ~flt;
    function automatic logic [7:0] res(input tbgpio_drive_t dv, ex, input logic [7:0] f);
        return (dv.oe & dv.out) | (~dv.oe & ex.oe & ex.out) | (~dv.oe & ~ex.oe & f);
    endfunction
    assign pin_a = res(dev_a, ext_a, flt);
    assign pin_b = res(dev_b, ext_b, flt);
    assign pin_c = res(dev_c, ext_c, flt);
endmodule // tbgpio_board

/* bench/tbgpio_chk.sv */
// checker: apb answer timing, error answers, smbus select and third bank drive
`timescale 1ns/1ns
module tbgpio_chk
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tbgpio_pkg::tbgpio_periph_t periph_req,
    input wire logic [7:0] sync_serial_status,
    input wire logic first_bank_smbus_levels,
    input wire logic [2:0] third_bank_pin_oe
);
    import tbgpio_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_setup_gets_ready: assert property (psel && !penable |=> pready) else $error("no answer");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
    a_idle_no_ready: assert property (!psel |=> !pready) else $error("stray ready");
    a_err_misaligned: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr) else $error("no err");
    a_mapped_no_err: assert property (psel && !penable && paddr == 12'h224 |=> !pslverr) else $error("err");
    a_err_data_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad err");
    a_smbus_follows: assert property (1'b1 |=> first_bank_smbus_levels == $past(periph_req.i2c_en
        && sync_serial_status[SSP_LEVEL_SEL_BIT])) else $error("smbus select wrong");
    // third bank drive moves only one edge after a register write lands
    a_third_oe_write: assert property ($changed(third_bank_pin_oe) |-> $past(psel && penable && pwrite, 2))
        else $error("third drive moved alone");
endmodule // tbgpio_chk
bind tbgpio_top tbgpio_chk tbgpio_chk_i (.*);

/* bench/tbgpio_top_tb.sv */
// testbench: registers, pin drive, peripheral override and slave port of the gpio
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tbgpio_top_tb;
    import tbgpio_pkg::*;
    logic ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, ce = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    tbgpio_periph_t periph_req = 20'h0_0800; // i2c on at first
    logic [7:0] sync_serial_status = 0, pin_a, pin_b, pin_c, v, d, e, lvl;
    tbgpio_drive_t dev_a, dev_b, dev_c, ext_a = 0, ext_b = 0, ext_c = 16'h07FF;
    int n_errors = 0, comparisons = 0, seed = 97376, i;
    int pn[5] = '{1, 2, 5, 6, 7}, en[5] = '{18, 15, 12, 4, 4}, ob[5] = '{16, 13, 5, 2, 0};
    tbgpio_top tbgpio_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_req(periph_req), .sync_serial_status(sync_serial_status),
        .first_bank_level(lvl), .first_bank_smbus_levels(), .first_bank_pin_in(pin_a),
        .first_bank_pin_out(dev_a.out), .first_bank_pin_oe(dev_a.oe), .second_bank_pin_in(pin_b),
        .second_bank_pin_out(dev_b.out), .second_bank_pin_oe(dev_b.oe), .third_bank_pin_in(pin_c[2:0]),
        .third_bank_pin_out(dev_c.out[2:0]), .third_bank_pin_oe(dev_c.oe[2:0]));
    tbgpio_board tbgpio_board_i (.ref_clk(ref_clk), .dev_a(dev_a), .dev_b(dev_b), .dev_c(dev_c),
        .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c));
    // the third bank has only three pins; the unused upper lanes never drive
    assign dev_c.out[7:3] = 5'h00;
    assign dev_c.oe[7:3] = 5'h00;
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) sync_serial_status <= $random(seed);
    // one apb transfer; request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dw);
        int k;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= dw;
        @(posedge ref_clk);
        penable <= 1;
        k = 0;
        do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 20);
        rd = prdata; er = pslverr;
        if (k >= 20) begin n_errors++; final_report; end
        psel <= 0; penable <= 0;
        @(posedge ref_clk);
    endtask
    task automatic rc(input logic [9:0] ix, input logic [7:0] ex);
        apb(0, {ix, 2'b00}, 0);
        `CHK(rd[7:0], ex)
    endtask
    task automatic wr(input logic [9:0] ix, input logic [7:0] dv); apb(1, {ix, 2'b00}, {24'h0, dv}); endtask
    task automatic cyc(input int n); repeat (n) @(posedge ref_clk); endtask
    // external micro writes one byte: write strobe and chip select low, then high with data still held
    task automatic pw(input logic [7:0] x);
        ext_b <= {x, 8'hFF}; ext_c <= 16'h01FF; cyc(5); ext_c <= 16'h07FF; cyc(6); ext_b <= 0; cyc(1);
    endtask
    function automatic logic [7:0] mix(input logic [7:0] o, dr, ev); return (o & ~dr) | (ev & dr); endfunction
    task final_report;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        cyc(5); arst_n <= 1; cyc(1);
        rc(IDX_FIRST_BANK_DIR, 8'hFF);
        rc(IDX_SECOND_BANK_DIR, 8'hFF);
        rc(IDX_THIRD_BANK_DIR, 8'h07);
        ext_c <= 16'h05FF; cyc(3); rc(IDX_THIRD_BANK_DATA, 8'h00);
        wr(IDX_ANALOG_PIN_CONFIG, 8'h04); rc(IDX_THIRD_BANK_DATA, 8'h01);
        wr(IDX_THIRD_BANK_DIR, 8'h00); cyc(1); `CHK(dev_c.oe[2:0], 3'h7)
        wr(IDX_THIRD_BANK_DIR, 8'h07);
        for (i = 0; i < 4; i++) begin
            v = $random(seed); d = (i == 0) ? 8'h00 : $random(seed); e = $random(seed); ext_a <= {e, d};
            wr(IDX_FIRST_BANK_DATA, v); wr(IDX_FIRST_BANK_DIR, d); cyc(1);
            `CHK(dev_a, {v, ~d})
            cyc(2); `CHK(lvl, mix(v, d, e))
            rc(IDX_FIRST_BANK_DATA, mix(v, d, e));
            wr(IDX_SECOND_BANK_DIR, e); cyc(1); `CHK(dev_b.oe, ~e)
        end
        wr(IDX_FIRST_BANK_DIR, 8'hFF);
        for (i = 0; i < 5; i++) begin
            periph_req <= 20'h0_0003 << ob[i]; cyc(2); `CHK(dev_a.oe[pn[i]], 1'b0)
            periph_req <= (20'h0_0003 << ob[i]) | (20'h0_0001 << en[i]); cyc(2);
            `CHK({dev_a.oe[pn[i]], dev_a.out[pn[i]]}, 2'b11)
            rc(IDX_FIRST_BANK_DIR, ~(8'h01 << pn[i]));
        end
        wr(IDX_FIRST_BANK_DIR, 8'h00); periph_req <= 20'h8_0000; cyc(2); `CHK(dev_a.oe[1:0], 2'b00)
        ce <= 0; periph_req <= 0; cyc(3); `CHK(dev_a.oe[1:0], 2'b00)
        ce <= 1; cyc(2); `CHK(dev_a.oe[1:0], 2'b11)
        apb(0, 12'h01D, 0); `CHK({er, rd}, 33'h1_0000_0000)
        apb(1, 12'h3FC, 32'h0000_00FF); `CHK(er, 1'b1)
        wr(IDX_ANALOG_PIN_CONFIG, 8'h00); wr(IDX_THIRD_BANK_DIR, 8'h17);
        v = $random(seed); pw(v); rc(IDX_THIRD_BANK_DIR, 8'h97);
        rc(IDX_SECOND_BANK_DATA, v);
        rc(IDX_THIRD_BANK_DIR, 8'h17);
        pw(~v); pw(v); rc(IDX_THIRD_BANK_DIR, 8'hB7);
        wr(IDX_THIRD_BANK_DIR, 8'h17); rc(IDX_THIRD_BANK_DIR, 8'h97);
        wr(IDX_SECOND_BANK_DATA, ~v); rc(IDX_THIRD_BANK_DIR, 8'hD7);
        ext_c <= 16'h02FF; cyc(6); `CHK(dev_b, {~v, 8'hFF})
        rc(IDX_THIRD_BANK_DIR, 8'h97); ext_c <= 16'h07FF;
        wr(IDX_THIRD_BANK_DIR, 8'h07); rc(IDX_THIRD_BANK_DIR, 8'h07);
        final_report;
    end
endmodule // tbgpio_top_tb

/* hw/tbgpio_pkg.sv */
// package: register map, field positions, reset values and carriers of the three-bank gpio
package tbgpio_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_FIRST_BANK_DATA = 10'h007; // first bank data latch / pins
    localparam logic [9:0] IDX_SECOND_BANK_DATA = 10'h008; // second bank data latch / pins
    localparam logic [9:0] IDX_THIRD_BANK_DATA = 10'h009; // third bank data latch / pins
    localparam logic [9:0] IDX_FIRST_BANK_DIR = 10'h087; // first bank direction
    localparam logic [9:0] IDX_SECOND_BANK_DIR = 10'h088; // second bank direction
    localparam logic [9:0] IDX_THIRD_BANK_DIR = 10'h089; // third bank direction and slave port control
    localparam logic [9:0] IDX_ANALOG_PIN_CONFIG = 10'h09F; // third bank analog selection

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int TB_INPUT_FULL_BIT = 7; // input_full_flag
    localparam int TB_OUTPUT_FULL_BIT = 6; // output_full_flag
    localparam int TB_INPUT_OVF_BIT = 5; // input_overflow_flag
    localparam int TB_SLAVE_MODE_BIT = 4; // slave_port_mode
    localparam int SSP_LEVEL_SEL_BIT = 6; // smbus level select in sync_serial_status
    localparam int RD_STROBE_PIN = 0; // third bank pin used as read strobe
    localparam int WR_STROBE_PIN = 1; // third bank pin used as write strobe
    localparam int CS_STROBE_PIN = 2; // third bank pin used as chip select

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] FIRST_BANK_DIR_RST = 8'hFF;
    localparam logic [7:0] SECOND_BANK_DIR_RST = 8'hFF;
    localparam logic [2:0] THIRD_BANK_DIR_RST = 3'h7;
    localparam logic [2:0] ANALOG_SEL_RST = 3'h7; // all third bank pins analog after power-on

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    // requests from the peripherals sharing the first bank
    typedef struct packed {
        logic sec_timer_osc_en; // secondary timer oscillator on bits 0 and 1
        logic capture_compare_two_en;
        logic capture_compare_two_out;
        logic capture_compare_two_oe;
        logic capture_compare_one_en;
        logic capture_compare_one_out;
        logic capture_compare_one_oe;
        logic sync_serial_en; // spi or i2c on bits 3 to 5
        logic i2c_en;
        logic sync_clock_out;
        logic sync_clock_oe;
        logic sync_data_out;
        logic sync_data_oe;
        logic serial_data_out_pin;
        logic serial_data_out_oe;
        logic usart_en; // usart on bits 6 and 7
        logic usart_sync_clock_pin;
        logic usart_sync_clock_oe;
        logic usart_sync_data_pin;
        logic usart_sync_data_oe;
    } tbgpio_periph_t;

    // drive of one bank of pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } tbgpio_drive_t;

endpackage

/* hw/tbgpio_top.sv */
// module: three-bank gpio with peripheral overrides and a parallel slave port, behind apb
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns

// Operation
// - first bank direction one tristates, zero drives
// - enabled peripheral overrides first bank direction
// - peripheral select steers latch or peripheral data
// - peripheral enable acts only under its select
// - i2c pins three, four switch smbus levels
// - bits 0-2 timer oscillator and capture/compare
// - bits 3-5 serve synchronous serial port
// - bits 6-7 serve the usart
// - data latches unreset; directions reset to inputs
// - second bank eight independently directed pins
// - slave port mode makes second bank data port
// - slave mode maps pin n to bit n
// - third bank three independently directed pins
// - slave mode makes third bank control inputs; direction still rules their drive
// - analog third bank pins read zero
// - direction still drives analog pins; keep inputs
// - third bank analog after power-on reset
// - third bank direction holds slave flags and mode
// - mode one slave port, zero plain gpio
// - pins 0,1,2 are read, write, chip select
module tbgpio_top
(
    input wire logic ref_clk, // core clock
    input wire logic arst_n, // asynchronous reset, active low
    input wire logic clk_en, // low freezes every flip-flop
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tbgpio_pkg::tbgpio_periph_t periph_req, // first bank peripheral requests
    input wire logic [7:0] sync_serial_status, // status byte of the serial port
    output logic [7:0] first_bank_level, // synchronised first bank pins for peripherals
    output logic first_bank_smbus_levels, // smbus thresholds on pins three and four
    input wire logic [7:0] first_bank_pin_in,
    output logic [7:0] first_bank_pin_out,
    output logic [7:0] first_bank_pin_oe,
    input wire logic [7:0] second_bank_pin_in,
    output logic [7:0] second_bank_pin_out,
    output logic [7:0] second_bank_pin_oe,
    input wire logic [2:0] third_bank_pin_in,
    output logic [2:0] third_bank_pin_out,
    output logic [2:0] third_bank_pin_oe
);
    import tbgpio_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] fb_latch_reg; // first bank output latch, no reset
    logic [7:0] sb_latch_reg; // second bank output latch, no reset
    logic [2:0] tb_latch_reg; // third bank output latch, no reset
    logic [7:0] sb_in_latch_reg; // slave port input latch, no reset
    logic [7:0] fb_dir_reg; // first bank direction
    logic [7:0] sb_dir_reg; // second bank direction
    logic [2:0] tb_dir_reg; // third bank direction
    logic [2:0] analog_sel_reg; // one marks an analog third bank pin
    logic slave_mode_reg; // slave_port_mode
    logic input_full_reg; // input_full_flag
    logic output_full_reg; // output_full_flag
    logic input_ovf_reg; // input_overflow_flag
    logic [7:0] fb_meta_reg; // first synchroniser stages
    logic [7:0] sb_meta_reg;
    logic [2:0] tb_meta_reg;
    logic [7:0] fb_sync_reg; // second synchroniser stages
    logic [7:0] sb_sync_reg;
    logic [2:0] tb_sync_reg;
    logic ps_wr_prev_reg; // slave write strobe active last cycle
    logic ps_rd_prev_reg; // slave read strobe active last cycle
    logic [31:0] rdata_reg;
    logic ready_reg;
    logic err_reg;
    logic [7:0] fb_out_reg;
    logic [7:0] fb_oe_reg;
    logic [7:0] sb_out_reg;
    logic [7:0] sb_oe_reg;
    logic [2:0] tb_out_reg;
    logic [2:0] tb_oe_reg;
    logic smbus_reg;

    // ----------------------------------------------------------------
    // combinational helpers
    // ----------------------------------------------------------------
    logic [9:0] idx; // word index of the request
    logic hit_fb_data, hit_sb_data, hit_tb_data;
    logic hit_fb_dir, hit_sb_dir, hit_tb_dir, hit_analog;
    logic mapped; // address decodes to a register
    logic wr_done; // write completes at this edge
    logic rd_done; // read completes at this edge
    logic [7:0] per_sel; // port/peripheral select per first bank pin
    logic [7:0] per_out; // peripheral data per pin
    logic [7:0] per_oe; // peripheral output enable per pin
    logic [7:0] fb_dir_eff; // direction after peripheral override
    logic [7:0] fb_oe_next;
    logic [7:0] fb_out_next;
    logic [2:0] tb_read; // third bank read value
    logic [31:0] rd_mux;
    logic ps_wr_act; // external write cycle in progress
    logic ps_rd_act; // external read cycle in progress

    assign idx = paddr[11:2];
    assign hit_fb_data = (idx == IDX_FIRST_BANK_DATA);
    assign hit_sb_data = (idx == IDX_SECOND_BANK_DATA);
    assign hit_tb_data = (idx == IDX_THIRD_BANK_DATA);
    assign hit_fb_dir = (idx == IDX_FIRST_BANK_DIR);
    assign hit_sb_dir = (idx == IDX_SECOND_BANK_DIR);
    assign hit_tb_dir = (idx == IDX_THIRD_BANK_DIR);
    assign hit_analog = (idx == IDX_ANALOG_PIN_CONFIG);
    // misaligned byte addresses are treated as unmapped
    assign mapped = (paddr[1:0] == 2'b00) & (hit_fb_data | hit_sb_data | hit_tb_data | hit_fb_dir
                    | hit_sb_dir | hit_tb_dir | hit_analog);
    assign wr_done = psel & penable & ready_reg & pwrite & mapped;
    assign rd_done = psel & penable & ready_reg & ~pwrite & mapped;

    // strobes are active low and only count in slave mode
    assign ps_wr_act = slave_mode_reg & ~tb_sync_reg[CS_STROBE_PIN] & ~tb_sync_reg[WR_STROBE_PIN];
    assign ps_rd_act = slave_mode_reg & ~tb_sync_reg[CS_STROBE_PIN] & ~tb_sync_reg[RD_STROBE_PIN];

    // ----------------------------------------------------------------
    // peripheral routing onto first bank pins
    // ----------------------------------------------------------------
    // each pin gets one select, one data and one enable from its owner
    always_comb
    begin
        per_sel = 8'h00;
        per_out = 8'h00;
        per_oe = 8'h00;
        // oscillator claims bits 0 and 1 as inputs, ahead of the second capture channel
        per_sel[0] = periph_req.sec_timer_osc_en;
        per_sel[1] = periph_req.sec_timer_osc_en | periph_req.capture_compare_two_en;
        per_out[1] = periph_req.capture_compare_two_out;
        per_oe[1] = ~periph_req.sec_timer_osc_en & periph_req.capture_compare_two_oe;
        per_sel[2] = periph_req.capture_compare_one_en;
        per_out[2] = periph_req.capture_compare_one_out;
        per_oe[2] = periph_req.capture_compare_one_oe;
        // serial clock, data in/out and data out
        per_sel[3] = periph_req.sync_serial_en;
        per_out[3] = periph_req.sync_clock_out;
        per_oe[3] = periph_req.sync_clock_oe;
        per_sel[4] = periph_req.sync_serial_en;
        per_out[4] = periph_req.sync_data_out;
        per_oe[4] = periph_req.sync_data_oe;
        per_sel[5] = periph_req.sync_serial_en;
        per_out[5] = periph_req.serial_data_out_pin;
        per_oe[5] = periph_req.serial_data_out_oe;
        // usart transmit/clock and receive/data
        per_sel[6] = periph_req.usart_en;
        per_out[6] = periph_req.usart_sync_clock_pin;
        per_oe[6] = periph_req.usart_sync_clock_oe;
        per_sel[7] = periph_req.usart_en;
        per_out[7] = periph_req.usart_sync_data_pin;
        per_oe[7] = periph_req.usart_sync_data_oe;
    end

    // per pin: the select picks both the data source and the enable source
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_fb_pin
            assign fb_out_next[gi] = per_sel[gi] ? per_out[gi] : fb_latch_reg[gi];
            // peripheral enable is ignored unless its select is active
            assign fb_oe_next[gi] = per_sel[gi] ? per_oe[gi] : ~fb_dir_reg[gi];
            // override shows in the read-back, which is why bit-wise updates are unsafe
            assign fb_dir_eff[gi] = per_sel[gi] ? ~per_oe[gi] : fb_dir_reg[gi];
        end
    endgenerate

    // analog pins read zero whatever their level
    assign tb_read = tb_sync_reg & ~analog_sel_reg;

    // ----------------------------------------------------------------
    // read multiplexer
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_fb_data)
            rd_mux[7:0] = fb_sync_reg;
        else if (hit_sb_data)
            // in slave mode software reads what the external master wrote
            rd_mux[7:0] = slave_mode_reg ? sb_in_latch_reg : sb_sync_reg;
        else if (hit_tb_data)
            rd_mux[2:0] = tb_read;
        else if (hit_fb_dir)
            rd_mux[7:0] = fb_dir_eff;
        else if (hit_sb_dir)
            rd_mux[7:0] = sb_dir_reg;
        else if (hit_tb_dir)
            // bit 3 is unimplemented and stays zero
            rd_mux[7:0] = {input_full_reg, output_full_reg, input_ovf_reg, slave_mode_reg, 1'b0,
                           tb_dir_reg};
        else if (hit_analog)
            rd_mux[2:0] = analog_sel_reg;
        else
            rd_mux = 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // apb slave: no wait state, answer from flip-flops
    // ----------------------------------------------------------------
    // ready rises in the first access cycle so every transfer takes two edges
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            ready_reg <= psel & ~penable & ~ready_reg;
            err_reg <= psel & ~penable & ~mapped;
            // data is sampled in the setup cycle and held through the access; refused reads answer zero
            if (psel & ~penable)
                rdata_reg <= (pwrite | ~mapped) ? 32'h0000_0000 : rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    // two stages; only the second stage is seen by any logic
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fb_meta_reg <= 8'h00;
            sb_meta_reg <= 8'h00;
            tb_meta_reg <= 3'h7;
            fb_sync_reg <= 8'h00;
            sb_sync_reg <= 8'h00;
            tb_sync_reg <= 3'h7; // strobes idle high
        end
        else if (clk_en)
        begin
            fb_meta_reg <= first_bank_pin_in;
            sb_meta_reg <= second_bank_pin_in;
            tb_meta_reg <= third_bank_pin_in;
            fb_sync_reg <= fb_meta_reg;
            sb_sync_reg <= sb_meta_reg;
            tb_sync_reg <= tb_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // data latches
    // ----------------------------------------------------------------
    // no reset at all: contents are unknown after power-up and survive other resets
    always_ff @(posedge ref_clk)
    begin
        if (clk_en)
        begin
            if (wr_done & hit_fb_data)
                fb_latch_reg <= pwdata[7:0];
            if (wr_done & hit_sb_data)
                sb_latch_reg <= pwdata[7:0];
            if (wr_done & hit_tb_data)
                tb_latch_reg <= pwdata[2:0];
            // the latch follows the bus while the external write is open
            if (ps_wr_act)
                sb_in_latch_reg <= sb_sync_reg;
        end
    end

    // ----------------------------------------------------------------
    // direction and analog configuration
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fb_dir_reg <= FIRST_BANK_DIR_RST;
            sb_dir_reg <= SECOND_BANK_DIR_RST;
            tb_dir_reg <= THIRD_BANK_DIR_RST;
            slave_mode_reg <= 1'b0;
            analog_sel_reg <= ANALOG_SEL_RST;
        end
        else if (clk_en)
        begin
            if (wr_done & hit_fb_dir)
                fb_dir_reg <= pwdata[7:0];
            if (wr_done & hit_sb_dir)
                sb_dir_reg <= pwdata[7:0];
            if (wr_done & hit_tb_dir)
            begin
                tb_dir_reg <= pwdata[2:0];
                slave_mode_reg <= pwdata[TB_SLAVE_MODE_BIT];
            end
            if (wr_done & hit_analog)
                analog_sel_reg <= pwdata[2:0];
        end
    end

    // ----------------------------------------------------------------
    // slave port flags
    // ----------------------------------------------------------------
    // a completed external cycle is the fall of its active condition
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ps_wr_prev_reg <= 1'b0;
            ps_rd_prev_reg <= 1'b0;
            input_full_reg <= 1'b0;
            output_full_reg <= 1'b0;
            input_ovf_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            ps_wr_prev_reg <= ps_wr_act;
            ps_rd_prev_reg <= ps_rd_act;
            if (!slave_mode_reg)
            begin
                // both full flags are held clear outside slave mode
                input_full_reg <= 1'b0;
                output_full_reg <= 1'b0;
            end
            else
            begin
                // end of write sets full; set beats a same-cycle software read
                if (ps_wr_prev_reg & ~ps_wr_act)
                    input_full_reg <= 1'b1;
                else if (rd_done & hit_sb_data)
                    input_full_reg <= 1'b0;
                // start of external read empties, software write fills
                if (wr_done & hit_sb_data)
                    output_full_reg <= 1'b1;
                else if (ps_rd_act & ~ps_rd_prev_reg)
                    output_full_reg <= 1'b0;
            end
            // overflow survives mode changes and is cleared only by software
            if (slave_mode_reg & ps_wr_prev_reg & ~ps_wr_act & input_full_reg)
                input_ovf_reg <= 1'b1;
            else if (wr_done & hit_tb_dir)
                input_ovf_reg <= pwdata[TB_INPUT_OVF_BIT];
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // registered so every pin output comes straight from a flip-flop
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fb_out_reg <= 8'h00;
            fb_oe_reg <= 8'h00;
            sb_out_reg <= 8'h00;
            sb_oe_reg <= 8'h00;
            tb_out_reg <= 3'h0;
            tb_oe_reg <= 3'h0;
            smbus_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            fb_out_reg <= fb_out_next;
            fb_oe_reg <= fb_oe_next;
            sb_out_reg <= sb_latch_reg;
            if (slave_mode_reg)
                // external master owns the direction; second bank direction is ignored
                sb_oe_reg <= {8{ps_rd_act}};
            else
                sb_oe_reg <= ~sb_dir_reg;
            tb_out_reg <= tb_latch_reg;
            // direction still rules in analog and slave use; software keeps inputs
            tb_oe_reg <= ~tb_dir_reg;
            smbus_reg <= periph_req.i2c_en & sync_serial_status[SSP_LEVEL_SEL_BIT];
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = err_reg;
    assign first_bank_level = fb_sync_reg;
    assign first_bank_smbus_levels = smbus_reg;
    assign first_bank_pin_out = fb_out_reg;
    assign first_bank_pin_oe = fb_oe_reg;
    assign second_bank_pin_out = sb_out_reg;
    assign second_bank_pin_oe = sb_oe_reg;
    assign third_bank_pin_out = tb_out_reg;
    assign third_bank_pin_oe = tb_oe_reg;

endmodule // tbgpio_top
